// file: csb_map.vh
`ifndef CSB_MAP_VH
`define CSB_MAP_VH
// ----------------------------------------
// Operation codes on op_in
// ----------------------------------------
`define CSB_OP_NONE 4'h0
`define CSB_OP_REG_COMPARE 4'h1
`define CSB_OP_REG_COMPARE_WITH_BORROW 4'h2
`define CSB_OP_IMMEDIATE_COMPARE 4'h3
`define CSB_OP_SKIP_ON_REG_BIT_LOW 4'h4
`define CSB_OP_SKIP_ON_REG_BIT_HIGH 4'h5
`define CSB_OP_SKIP_ON_IO_BIT_LOW 4'h6
`define CSB_OP_SKIP_ON_IO_BIT_HIGH 4'h7
`define CSB_OP_BRANCH_ON_FLAG_HIGH 4'h8
`define CSB_OP_BRANCH_ON_FLAG_LOW 4'h9
`define CSB_OP_BRANCH_ON_EQUAL 4'ha
`define CSB_OP_BRANCH_ON_UNEQUAL 4'hb
`define CSB_OP_BRANCH_ON_BORROW_HIGH 4'hc
`define CSB_OP_BRANCH_ON_BORROW_LOW 4'hd
`define CSB_OP_BRANCH_ON_UNSIGNED_GE 4'he
`define CSB_OP_BRANCH_ON_UNSIGNED_LT 4'hf
// ----------------------------------------
// Flag register bit positions
// ----------------------------------------
`define CSB_FLAG_C 0
`define CSB_FLAG_Z 1
`define CSB_FLAG_N 2
`define CSB_FLAG_V 3
`define CSB_FLAG_S 4
`define CSB_FLAG_H 5
// ----------------------------------------
// Reset values and cycle counts
// ----------------------------------------
`define CSB_FLAGS_RESET 8'h00
`define CSB_PC_RESET 16'h0000
`define CSB_CYC_PLAIN 2'h1
`define CSB_CYC_TAKEN 2'h2
`define CSB_CYC_SKIP_LONG 2'h3
`define CSB_PC_STEP 2'h1
`define CSB_SKIP_SHORT 2'h2
`define CSB_SKIP_LONG 2'h3
`endif

// file: csb_compare_skip_branch_unit.v
`timescale 1ns/1ps
`include "csb_map.vh"
module csb_compare_skip_branch_unit #(
	parameter PC_W = 16
) (
	input wire clk_in,
	input wire srst_in,
	input wire start_in,
	input wire [3:0] op_in,
	input wire [7:0] dst_in,
	input wire [7:0] src_in,
	input wire [7:0] imm_in,
	input wire [7:0] io_in,
	input wire [2:0] bit_in,
	input wire [6:0] offset_in,
	input wire next_two_word_in,
	input wire [PC_W-1:0] pc_in,
	input wire [7:0] flags_in,
	output reg [PC_W-1:0] pc_out,
	output reg [7:0] flags_out,
	output reg flags_we_out,
	output reg done_out,
	output reg busy_out,
	output reg [1:0] cycles_out
);
// ----------------------------------------
// States
// ----------------------------------------
localparam ST_IDLE = 2'b01;
localparam ST_WAIT = 2'b10;
reg [1:0] state;
reg [1:0] remain;
reg [PC_W-1:0] pend_pc;
// ----------------------------------------
// Compare arithmetic, shared by all compares
// ----------------------------------------
// Nine-bit difference; bit 8 is the borrow out of the top bit
function [8:0] cmp_diff;
	input [7:0] a;
	input [7:0] b;
	input cin;
	begin
		cmp_diff = {1'b0, a} - {1'b0, b} - {8'h00, cin};
	end
endfunction
// Borrow out of bit 3
function half_borrow;
	input [7:0] a;
	input [7:0] b;
	input [7:0] d;
	begin
		half_borrow = (~a[3] & b[3]) | (b[3] & d[3]) | (d[3] & ~a[3]);
	end
endfunction
// Two's complement overflow of a minus b
function sub_overflow;
	input [7:0] a;
	input [7:0] b;
	input [7:0] d;
	begin
		sub_overflow = (a[7] & ~b[7] & ~d[7]) | (~a[7] & b[7] & d[7]);
	end
endfunction
function [7:0] cmp_flags;
	input [7:0] a;
	input [7:0] b;
	input cin;
	input keep_z;
	input [7:0] old;
	reg [8:0] d;
	reg [7:0] f;
	begin
		d = cmp_diff(a, b, cin);
		f = old;
		f[`CSB_FLAG_C] = d[8];
		f[`CSB_FLAG_H] = half_borrow(a, b, d[7:0]);
		f[`CSB_FLAG_N] = d[7];
		f[`CSB_FLAG_V] = sub_overflow(a, b, d[7:0]);
		// Borrow chain keeps Z only if it was already set, as multi-byte compare needs
		f[`CSB_FLAG_Z] = (d[7:0] == 8'h00) & (~keep_z | old[`CSB_FLAG_Z]);
		f[`CSB_FLAG_S] = f[`CSB_FLAG_N] ^ f[`CSB_FLAG_V];
		cmp_flags = f;
	end
endfunction
// ----------------------------------------
// Counter arithmetic
// ----------------------------------------
// Wraps at the top of the counter, as the core's own counter does
function [PC_W-1:0] pc_add;
	input [PC_W-1:0] base;
	input [PC_W-1:0] step;
	begin
		pc_add = base + step;
	end
endfunction
// Widen a small unsigned step to counter width
function [PC_W-1:0] pc_step;
	input [1:0] n;
	begin
		pc_step = {{(PC_W-2){1'b0}}, n};
	end
endfunction
// Sign-extend the seven-bit offset
function [PC_W-1:0] sext_offset;
	input [6:0] k;
	begin
		sext_offset = {{(PC_W-7){k[6]}}, k};
	end
endfunction
// Skips follow the length of what they pass over
function [1:0] cost_of;
	input skip;
	input taken;
	input two_word;
	begin
		if (!taken)
			cost_of = `CSB_CYC_PLAIN;
		else if (skip && two_word)
			cost_of = `CSB_CYC_SKIP_LONG;
		else
			cost_of = `CSB_CYC_TAKEN;
	end
endfunction
// ----------------------------------------
// Bit pick, shared by skips and flag branches
// ----------------------------------------
function pick_bit;
	input [7:0] v;
	input [2:0] sel;
	begin
		pick_bit = v[sel];
	end
endfunction
// ----------------------------------------
// Decode
// ----------------------------------------
reg is_cmp;
reg is_skip;
reg is_br;
reg cond;
reg [7:0] next_flags;
wire [1:0] skip_step = next_two_word_in ? `CSB_SKIP_LONG : `CSB_SKIP_SHORT;
wire [PC_W-1:0] pc_seq = pc_add(pc_in, pc_step(`CSB_PC_STEP));
wire [PC_W-1:0] pc_br = pc_add(pc_seq, sext_offset(offset_in));
wire [PC_W-1:0] pc_skip = pc_add(pc_in, pc_step(skip_step));
always @* begin
	is_cmp = 1'b0;
	is_skip = 1'b0;
	is_br = 1'b0;
	cond = 1'b0;
	next_flags = flags_in;
	case (op_in)
		`CSB_OP_REG_COMPARE: begin
			is_cmp = 1'b1;
			next_flags = cmp_flags(dst_in, src_in, 1'b0, 1'b0, flags_in);
		end
		`CSB_OP_REG_COMPARE_WITH_BORROW: begin
			is_cmp = 1'b1;
			next_flags = cmp_flags(dst_in, src_in, flags_in[`CSB_FLAG_C], 1'b1, flags_in);
		end
		`CSB_OP_IMMEDIATE_COMPARE: begin
			is_cmp = 1'b1;
			next_flags = cmp_flags(dst_in, imm_in, 1'b0, 1'b0, flags_in);
		end
		`CSB_OP_SKIP_ON_REG_BIT_LOW: begin
			is_skip = 1'b1;
			cond = ~pick_bit(src_in, bit_in);
		end
		`CSB_OP_SKIP_ON_REG_BIT_HIGH: begin
			is_skip = 1'b1;
			cond = pick_bit(src_in, bit_in);
		end
		`CSB_OP_SKIP_ON_IO_BIT_LOW: begin
			is_skip = 1'b1;
			cond = ~pick_bit(io_in, bit_in);
		end
		`CSB_OP_SKIP_ON_IO_BIT_HIGH: begin
			is_skip = 1'b1;
			cond = pick_bit(io_in, bit_in);
		end
		`CSB_OP_BRANCH_ON_FLAG_HIGH: begin
			is_br = 1'b1;
			cond = pick_bit(flags_in, bit_in);
		end
		`CSB_OP_BRANCH_ON_FLAG_LOW: begin
			is_br = 1'b1;
			cond = ~pick_bit(flags_in, bit_in);
		end
		`CSB_OP_BRANCH_ON_EQUAL: begin
			is_br = 1'b1;
			cond = flags_in[`CSB_FLAG_Z];
		end
		`CSB_OP_BRANCH_ON_UNEQUAL: begin
			is_br = 1'b1;
			cond = ~flags_in[`CSB_FLAG_Z];
		end
		`CSB_OP_BRANCH_ON_BORROW_HIGH, `CSB_OP_BRANCH_ON_UNSIGNED_LT: begin
			is_br = 1'b1;
			cond = flags_in[`CSB_FLAG_C];
		end
		`CSB_OP_BRANCH_ON_BORROW_LOW, `CSB_OP_BRANCH_ON_UNSIGNED_GE: begin
			is_br = 1'b1;
			cond = ~flags_in[`CSB_FLAG_C];
		end
		default: begin
			cond = 1'b0;
		end
	endcase
end
// ----------------------------------------
// Outcome and cycle cost
// ----------------------------------------
reg [PC_W-1:0] next_pc;
reg [1:0] next_cycles;
always @* begin
	next_pc = pc_seq;
	next_cycles = cost_of(is_skip, 1'b0, next_two_word_in);
	if (is_skip && cond) begin
		next_pc = pc_skip;
		next_cycles = cost_of(1'b1, 1'b1, next_two_word_in);
	end else if (is_br && cond) begin
		next_pc = pc_br;
		next_cycles = cost_of(1'b0, 1'b1, next_two_word_in);
	end
end
// ----------------------------------------
// Accept
// ----------------------------------------
// Requests while waiting are dropped without any sign
wire accept = start_in & (state == ST_IDLE);
// ----------------------------------------
// Sequencer
// ----------------------------------------
// The new counter is held until the last cycle so the core sees one clean commit
always @(posedge clk_in) begin
	if (srst_in) begin
		state <= ST_IDLE;
		remain <= 2'h0;
		pend_pc <= `CSB_PC_RESET;
		pc_out <= `CSB_PC_RESET;
		flags_we_out <= 1'b0;
		done_out <= 1'b0;
		busy_out <= 1'b0;
	end else begin
		done_out <= 1'b0;
		flags_we_out <= 1'b0;
		case (state)
			ST_IDLE: begin
				if (accept) begin
					if (next_cycles == `CSB_CYC_PLAIN) begin
						pc_out <= next_pc;
						done_out <= 1'b1;
						flags_we_out <= is_cmp;
					end else begin
						pend_pc <= next_pc;
						remain <= next_cycles - 2'h1;
						busy_out <= 1'b1;
						state <= ST_WAIT;
					end
				end
			end
			ST_WAIT: begin
				if (remain == 2'h1) begin
					pc_out <= pend_pc;
					done_out <= 1'b1;
					busy_out <= 1'b0;
					state <= ST_IDLE;
				end
				remain <= remain - 2'h1;
			end
			default: begin
				state <= ST_IDLE;
				busy_out <= 1'b0;
			end
		endcase
	end
end
// ----------------------------------------
// Result registers
// ----------------------------------------
// Loaded at accept only; they stand until the next accept
always @(posedge clk_in) begin
	if (srst_in) begin
		cycles_out <= 2'h0;
		flags_out <= `CSB_FLAGS_RESET;
	end else if (accept) begin
		cycles_out <= next_cycles;
		flags_out <= next_flags;
	end
end
endmodule

// file: csb_checker.sv
`timescale 1ns/1ps
module csb_checker #(parameter PC_W = 16) (
	input wire clk_in, input wire srst_in, input wire start_in,
	input wire [3:0] op_in, input wire [7:0] src_in, input wire [2:0] bit_in,
	input wire [7:0] flags_in, input wire [PC_W-1:0] pc_in,
	input wire [PC_W-1:0] pc_out, input wire [1:0] cycles_out,
	input wire flags_we_out, input wire done_out, input wire busy_out
);
	// ----
	// Accept
	// ----
	wire acc = start_in && !busy_out;
	wire cmp = op_in != 4'h0 && op_in < 4'h4;
	wire rb = src_in[bit_in];
	wire z = flags_in[1];
	default clocking @(posedge clk_in); endclocking
	default disable iff (srst_in);
	cmp_one_a: assert property (acc && cmp |=> done_out && flags_we_out && cycles_out == 2'h1)
		else $error("compare length");
	we_cmp_a: assert property (flags_we_out |-> done_out && $past(cmp))
		else $error("stray flag write");
	skip_miss_a: assert property (acc && op_in == 4'h4 && rb |=> done_out && pc_out == $past(pc_in) + 1'b1)
		else $error("skip low miss");
	skip_hit_a: assert property (acc && op_in == 4'h5 && rb |=> busy_out && cycles_out != 2'h1)
		else $error("skip high hit");
	two_cyc_a: assert property ($rose(busy_out) && cycles_out == 2'h2 |=> done_out && !busy_out)
		else $error("cost two");
	three_cyc_a: assert property ($rose(busy_out) && cycles_out == 2'h3 |=> busy_out ##1 done_out && !busy_out)
		else $error("cost three");
	busy_quiet_a: assert property (busy_out |-> !done_out && !flags_we_out)
		else $error("done while busy");
	eq_fall_a: assert property (acc && op_in == 4'ha && !z |=> done_out && pc_out == $past(pc_in) + 1'b1)
		else $error("equal fall");
	ne_take_a: assert property (acc && op_in == 4'hb && !z |=> busy_out && cycles_out == 2'h2)
		else $error("unequal take");
	cover property (done_out && flags_we_out);
	cover property ($rose(busy_out) && cycles_out == 2'h3);
	cover property (acc && op_in == 4'hb && !z);
endmodule
bind csb_compare_skip_branch_unit csb_checker #(.PC_W(PC_W)) csb_checker_i (
	.clk_in(clk_in), .srst_in(srst_in), .start_in(start_in), .op_in(op_in), .src_in(src_in),
	.bit_in(bit_in), .flags_in(flags_in), .pc_in(pc_in), .pc_out(pc_out),
	.cycles_out(cycles_out), .flags_we_out(flags_we_out), .done_out(done_out),
	.busy_out(busy_out));

// file: test_compare_skip_branch_unit.sv
`timescale 1ns/1ps
module test_compare_skip_branch_unit;
	reg clk_in = 1'b0, srst_in = 1'b1, start_in = 1'b0, next_two_word_in = 1'b0;
	reg [3:0] op_in = 4'h0;
	reg [7:0] dst_in = 8'h00, src_in = 8'h00, imm_in = 8'h00, io_in = 8'h00, flags_in = 8'h00;
	reg [2:0] bit_in = 3'h1;
	reg [6:0] offset_in = 7'h00;
	reg [15:0] pc_in = 16'h0100, pe;
	reg [1:0] n, ce;
	wire [15:0] pc_out;
	wire [7:0] flags_out;
	wire flags_we_out, done_out, busy_out;
	wire [1:0] cycles_out;
	integer num_errors = 0, check_count = 0, cyc = 0, i, j;
	csb_compare_skip_branch_unit #(.PC_W(16)) csb_compare_skip_branch_unit_i (
		.clk_in(clk_in), .srst_in(srst_in), .start_in(start_in), .op_in(op_in),
		.dst_in(dst_in), .src_in(src_in), .imm_in(imm_in), .io_in(io_in), .bit_in(bit_in),
		.offset_in(offset_in), .next_two_word_in(next_two_word_in), .pc_in(pc_in),
		.flags_in(flags_in), .pc_out(pc_out), .flags_out(flags_out),
		.flags_we_out(flags_we_out), .done_out(done_out), .busy_out(busy_out),
		.cycles_out(cycles_out));
	initial forever #4 clk_in = ~clk_in;
	task end_of_test;
		begin
			$display("checks %0d mismatches %0d", check_count, num_errors);
			if (num_errors == 0 && check_count > 0)
				$display("ALL TESTS PASSED");
			else
				$display("TESTS FAILED");
			$finish;
		end
	endtask
	task chk(input [15:0] g, input [15:0] e);
		begin
			check_count = check_count + 1;
			if (g !== e) begin
				num_errors = num_errors + 1;
				$display("mismatch at %0t got %h exp %h", $time, g, e);
			end
		end
	endtask
	// ----
	// One op: launch, wait bounded, judge
	// ----
	task go(input [7:0] fe, input we);
		begin
			start_in = 1'b1;
			@(posedge clk_in);
			#1 start_in = 1'b0;
			n = 2'h0;
			while (done_out !== 1'b1 && n != 2'h3) begin
				@(posedge clk_in);
				#1 n = n + 2'h1;
			end
			chk(done_out, 1'b1);
			chk(n + 2'h1, ce);
			chk(cycles_out, ce);
			chk(pc_out, pe);
			chk(flags_out, fe);
			chk(flags_we_out, we);
			@(posedge clk_in);
			#1;
		end
	endtask
	// Other operand is inverted so a wrong source is caught
	task cmp(input [3:0] op, input [7:0] d, input [7:0] s, input [7:0] f, input [7:0] e);
		begin
			op_in = op;
			dst_in = d;
			src_in = op == 4'h3 ? ~s : s;
			imm_in = op == 4'h3 ? s : ~s;
			flags_in = f;
			ce = 2'h1;
			pe = 16'h0101;
			go(e, 1'b1);
		end
	endtask
	task t_skip;
		begin
			flags_in = 8'h5a;
			for (i = 4; i < 8; i = i + 1) for (j = 0; j < 3; j = j + 1) begin
				op_in = i;
				src_in = i < 6 ? 8'h04 : 8'hfb;
				io_in = ~src_in;
				bit_in = ((i % 2 == 1) ^ (j == 2)) ? 3'h2 : 3'h3;
				next_two_word_in = j != 0;
				ce = j == 2 ? 2'h1 : j + 2;
				pe = 16'h0100 + ce;
				go(8'h5a, 1'b0);
			end
			$display("skip test done");
		end
	endtask
	task t_branch;
		begin
			bit_in = 3'h1;
			for (i = 8; i < 16; i = i + 1) for (j = 0; j < 2; j = j + 1) begin
				op_in = i;
				flags_in = j ? 8'ha3 : 8'h5c;
				offset_in = j ? 7'h3f : 7'h40;
				ce = (j ^ (i == 9 || i == 11 || i == 13 || i == 14)) ? 2'h2 : 2'h1;
				pe = ce == 2'h2 ? 16'h0101 + {{9{offset_in[6]}}, offset_in} : 16'h0101;
				go(flags_in, 1'b0);
			end
			$display("branch test done");
		end
	endtask
	always @(posedge clk_in) begin
		cyc = cyc + 1;
		if (cyc == 5000) begin
			num_errors = num_errors + 1;
			end_of_test;
		end
	end
	initial begin
		repeat (3) @(posedge clk_in);
		#1 srst_in = 1'b0;
		chk(pc_out, 16'h0000);
		chk(flags_out, 8'h00);
		chk(cycles_out, 2'h0);
		chk(done_out, 1'b0);
		chk(busy_out, 1'b0);
		chk(flags_we_out, 1'b0);
		$display("reset test done");
		cmp(4'h1, 8'h10, 8'h10, 8'hc0, 8'hc2);
		cmp(4'h1, 8'h00, 8'h01, 8'hc0, 8'hf5);
		cmp(4'h2, 8'h05, 8'h04, 8'hc3, 8'hc2);
		cmp(4'h3, 8'h80, 8'h01, 8'hc0, 8'hf8);
		op_in = 4'h0;
		ce = 2'h1;
		pe = 16'h0101;
		go(flags_in, 1'b0);
		$display("compare test done");
		t_skip;
		t_branch;
		end_of_test;
	end
endmodule
